// >>> design/rawc_cfg.svh
`ifndef RAWC_CFG_SVH
`define RAWC_CFG_SVH

// ==========================================
// Register offsets.
`define RAWC_A_HUND   4'h0
`define RAWC_A_SEC    4'h1
`define RAWC_A_MIN    4'h2
`define RAWC_A_AMIN   4'h3
`define RAWC_A_HOUR   4'h4
`define RAWC_A_AHOUR  4'h5
`define RAWC_A_DAY    4'h6
`define RAWC_A_ADAY   4'h7
`define RAWC_A_DATE   4'h8
`define RAWC_A_MON    4'h9
`define RAWC_A_YEAR   4'hA
`define RAWC_A_CMD    4'hB
`define RAWC_A_WDLO   4'hC
`define RAWC_A_WDHI   4'hD

// ==========================================
// Field masks and bit positions.
`define RAWC_M_SEC    8'h7F
`define RAWC_M_HOUR   8'h7F
`define RAWC_M_DAY    8'h07
`define RAWC_M_DATE   8'h3F
`define RAWC_M_MON    8'h1F
`define RAWC_M_ADAY   8'h87
`define RAWC_B_OSC    7
`define RAWC_B_SQW    6
`define RAWC_B_TE     5
`define RAWC_B_ROUTE  4
`define RAWC_B_BPOL   3
`define RAWC_B_PULSE  2
`define RAWC_B_WAM    1
`define RAWC_B_TDM    0

// ==========================================
// Reset values; the command field holds register bits 7 to 2.
`define RAWC_CMD_RST  6'h33
`define RAWC_ONE_RST  8'h01

// ==========================================
// Timing.
`define RAWC_MCLK_HZ  10000000
`define RAWC_XTAL_HZ  32768
`define RAWC_TICK_HZ  16'h0064
`define RAWC_SQW_HALF 4'hF
`define RAWC_PULSE_MS 3

`endif

// >>> design/rawc_pkg.sv
package rawc_pkg;

    // Time-of-day set, one BCD byte per field.
    typedef struct packed {
        logic [7:0] hund, sec, min, hour, day, date, month, year;
    } rawc_time_t;

    // Whole state of the core.
    typedef struct packed {
        rawc_time_t  itm, etm;
        logic [7:0]  alm_min, alm_hr, alm_day;
        logic        osc_stop_n, sqw_off;
        logic [5:0]  cmd;
        logic [7:0]  wd_lo, wd_hi;
        logic [15:0] wd_cnt;
        logic        tod_flag, wd_flag;
        logic [15:0] tod_pls, wd_pls;
        logic [14:0] acc;
        logic [3:0]  sq_div;
        logic        sqw, xtal_q, wr_q, rd_q;
        logic [7:0]  rdata;
        logic        dq_oe_b, irq_a_oe_b, irq_b_o, irq_b_oe_b, sqw_oe_b;
    } rawc_state_t;

endpackage : rawc_pkg

// >>> design/rawc_cal_if.sv
`timescale 1ns/1ps
`default_nettype none
interface rawc_cal_if import rawc_pkg::*;;
    rawc_time_t cur;
    rawc_time_t nxt;
    logic       min_roll;
    modport core (output cur, input nxt, input min_roll);
    modport cal  (input cur, output nxt, output min_roll);
endinterface : rawc_cal_if
`default_nettype wire

// >>> design/rawc_cal.sv
`timescale 1ns/1ps
`default_nettype none
`include "rawc_cfg.svh"
module rawc_cal import rawc_pkg::*; (
    // Calendar link to the core.
    rawc_cal_if.cal cal
);

    logic [8:0] hc, sc, mc, hx, dy, dt, mo, yr;
    logic       dcarry;
    logic [7:0] last;
    logic       leap;

    // BCD increment with wrap; bit 8 is the carry.
    function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
        if (v == hi) begin
            bcd_inc = {1'b1, lo};
        end else if (v[3:0] == 4'h9) begin
            bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
        end else begin
            bcd_inc = {1'b0, v[7:4], v[3:0] + 4'h1};
        end
    endfunction : bcd_inc

    // Leap years are those divisible by four, worked out on the BCD digits.
    assign leap = cal.cur.year[4] ? (cal.cur.year[3:0] == 4'h2 || cal.cur.year[3:0] == 4'h6)
                                  : (cal.cur.year[3:0] == 4'h0 || cal.cur.year[3:0] == 4'h4 ||
                                     cal.cur.year[3:0] == 4'h8);

    // Last date of the running month.
    always_comb begin
        case (cal.cur.month)
            8'h02:                      last = leap ? 8'h29 : 8'h28; // see R23
            8'h04, 8'h06, 8'h09, 8'h11: last = 8'h30;                // see R23
            default:                    last = 8'h31;
        endcase
    end

    // Advance one hundredth; the larger fields move only on the 99 to 00 roll.
    always_comb begin
        cal.nxt      = cal.cur;
        cal.min_roll = 1'b0;
        dcarry       = 1'b0;
        sc           = '0;
        mc           = '0;
        hx           = '0;
        dy           = '0;
        dt           = '0;
        mo           = '0;
        yr           = '0;
        hc           = bcd_inc(cal.cur.hund, 8'h00, 8'h99);
        cal.nxt.hund = hc[7:0];
        if (hc[8]) begin // see R7
            sc          = bcd_inc(cal.cur.sec, 8'h00, 8'h59);
            cal.nxt.sec = sc[7:0];
            if (sc[8]) begin
                cal.min_roll = 1'b1;
                mc           = bcd_inc(cal.cur.min, 8'h00, 8'h59);
                cal.nxt.min  = mc[7:0];
            end
            if (mc[8]) begin
                if (cal.cur.hour[6]) begin // see R4
                    if (cal.cur.hour[4:0] == 5'h12) begin
                        cal.nxt.hour = {cal.cur.hour[7:5], 5'h01};
                    end else if (cal.cur.hour[4:0] == 5'h11) begin
                        cal.nxt.hour = {cal.cur.hour[7:6], ~cal.cur.hour[5], 5'h12};
                        dcarry       = cal.cur.hour[5];
                    end else begin
                        hx           = bcd_inc({3'b000, cal.cur.hour[4:0]}, 8'h01, 8'h12);
                        cal.nxt.hour = {cal.cur.hour[7:5], hx[4:0]};
                    end
                end else begin
                    hx           = bcd_inc({2'b00, cal.cur.hour[5:0]}, 8'h00, 8'h23);
                    cal.nxt.hour = {cal.cur.hour[7:6], hx[5:0]};
                    dcarry       = hx[8];
                end
            end
            if (dcarry) begin
                dy           = bcd_inc(cal.cur.day, 8'h01, 8'h07);
                dt           = bcd_inc(cal.cur.date, 8'h01, last);
                cal.nxt.day  = dy[7:0];
                cal.nxt.date = dt[7:0];
            end
            if (dt[8]) begin
                mo            = bcd_inc(cal.cur.month, 8'h01, 8'h12);
                cal.nxt.month = mo[7:0];
            end
            if (mo[8]) begin
                yr           = bcd_inc(cal.cur.year, 8'h00, 8'h99);
                cal.nxt.year = yr[7:0];
            end
        end
    end

endmodule : rawc_cal
`default_nettype wire

// >>> design/rawc_core.sv
// Function
// R1: Unused bits of time-of-day registers always read zero.
// R2: Months bit 7 at 1 halts the oscillator, at 0 runs it.
// R3: Months bit 6 at 0 gives a 1024 Hz square wave, at 1 high impedance.
// R4: Hours bit 6 picks 12-hour mode; bit 5 is PM or tens-of-twenty.
// R5: Visible time refreshes each hundredth unless transfers are off or oscillator stopped.
// R6: Internal time keeps counting while the visible copy is frozen.
// R7: On the 99 to 00 roll, larger fields advance, alarm is checked, copy made.
// R8: Software should freeze transfers around time accesses, then re-enable them.
// R9: Day alarm bits 3 to 6 always read zero.
// R10: Alarm mask bits select weekly, daily or hourly matches.
// R11: All three masks set alarm every minute at the seconds roll.
// R12: Any alarm register access clears the time alarm flag and its output.
// R13: Watchdog interval is four BCD digits, any access order.
// R14: Watchdog register access reloads the countdown and clears flag and output.
// R15: At zero the watchdog alarms, reloads, and repeats.
// R16: Watchdog registers read the interval, never the running count.
// R17: A zero interval disables the watchdog alarm.
// R18: Command bit 6 swaps which alarm drives which interrupt pin.
// R19: Command bit 5 makes pin B source current with supply present, else sink.
// R20: Command bit 4 selects level or pulse mode; pulses last at least 3 ms.
// R21: Command bits 3 and 2 mask watchdog and time alarm outputs.
// R22: Flag bits set on alarm, clear on access, follow the pulse in pulse mode.
// R23: Month end follows month length with the leap-year February.
// R24: Time, date and alarm fields are BCD; command bits are binary.
// R25: Hundredths tick and square wave come from the 32.768 kHz crystal.
// R26: Watchdog counts down per hundredth and alarms when reaching zero.
`timescale 1ns/1ps
`default_nettype none
`include "rawc_cfg.svh"
module rawc_core import rawc_pkg::*; #(
    parameter int PULSE_CYC = (`RAWC_PULSE_MS * `RAWC_MCLK_HZ + 999) / 1000
) (
    // Clock and reset.
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Crystal and supply sense.
    input  wire logic       xtal_clk,
    input  wire logic       vcc_ok,
    // Memory-style host bus.
    input  wire logic       ce_b,
    input  wire logic       oe_b,
    input  wire logic       we_b,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] dq_i,
    output logic      [7:0] dq_o,
    output logic            dq_oe_b,
    // Interrupt pins.
    output logic            irq_out_a,
    output logic            irq_a_oe_b,
    output logic            irq_out_b,
    output logic            irq_b_oe_b,
    // Square wave pin.
    output logic            sqw_o,
    output logic            sqw_oe_b
);

    // ==========================================
    // Constants and checks.
    localparam rawc_time_t TM_RST = '{day: `RAWC_ONE_RST, date: `RAWC_ONE_RST,
                                      month: `RAWC_ONE_RST, default: '0};
    localparam rawc_state_t ST_RST = '{itm: TM_RST, etm: TM_RST, osc_stop_n: 1'b1,
                                       sqw_off: 1'b1, cmd: `RAWC_CMD_RST, dq_oe_b: 1'b1,
                                       irq_a_oe_b: 1'b1, irq_b_oe_b: 1'b1, sqw_oe_b: 1'b1,
                                       default: '0};
    localparam logic [15:0] PLS = PULSE_CYC[15:0];

    // The pulse counter is sixteen bits and the tick uses a power-of-two crystal.
    if (PULSE_CYC < 4 || PULSE_CYC > 65535 || `RAWC_XTAL_HZ != 32768) begin : g_bad
        $error("rawc_core: PULSE_CYC out of range or unsupported crystal rate");
    end

    // ==========================================
    // Signals.
    rawc_state_t s_r, s_nxt;
    rawc_cal_if  cif ();
    logic        wr_now, rd_now, wr_st, rd_st, acc_st, xedge, tick;
    logic [15:0] sum, wd_iv;
    logic        te, route, bpol, pulse, wdog_irq_mask, tdm;
    logic        m_ok, h_ok, d_ok, tod_evt, wd_evt, tod_clr, wd_clr;
    logic        tod_act, wd_act, a_act, b_act;

    // Access to any of the three alarm registers.
    function automatic logic is_alm(input logic [3:0] a);
        is_alm = (a == `RAWC_A_AMIN) || (a == `RAWC_A_AHOUR) || (a == `RAWC_A_ADAY);
    endfunction : is_alm

    // Access to either watchdog register.
    function automatic logic is_wd(input logic [3:0] a);
        is_wd = (a == `RAWC_A_WDLO) || (a == `RAWC_A_WDHI);
    endfunction : is_wd

    // Four-digit BCD decrement.
    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (b) begin
                if (r[4*i +: 4] == 4'h0) begin
                    r[4*i +: 4] = 4'h9;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        bcd_dec = r;
    endfunction : bcd_dec

    // ==========================================
    // Calendar arithmetic works on the internal copy.
    assign cif.cur = s_r.itm; // see R6
    rawc_cal u_cal (
        .cal (cif.cal)
    );

    // ==========================================
    // Command fields.
    assign te    = s_r.cmd[`RAWC_B_TE];
    assign route = s_r.cmd[`RAWC_B_ROUTE];
    assign bpol  = s_r.cmd[`RAWC_B_BPOL];
    assign pulse = s_r.cmd[`RAWC_B_PULSE];
    assign wdog_irq_mask   = s_r.cmd[`RAWC_B_WAM];
    assign tdm   = s_r.cmd[`RAWC_B_TDM];

    // Bus strobes; an access is acted on in its first active cycle only.
    assign wr_now  = !ce_b && !we_b;
    assign rd_now  = !ce_b && !oe_b && we_b;
    assign wr_st   = wr_now && !s_r.wr_q;
    assign rd_st   = rd_now && !s_r.rd_q;
    assign acc_st  = wr_st || rd_st;
    assign tod_clr = acc_st && is_alm(addr); // see R12
    assign wd_clr  = acc_st && is_wd(addr);  // see R14

    // Crystal prescaler: a phase accumulator steps 100 per edge and wraps at 32768,
    // which gives exactly 100 ticks per second with a binary divider.
    assign xedge = xtal_clk && !s_r.xtal_q;
    assign sum   = {1'b0, s_r.acc} + `RAWC_TICK_HZ;
    assign tick  = xedge && !s_r.osc_stop_n && sum[15]; // see R25 see R2

    // Alarm compare against the freshly advanced time, once per minute roll.
    assign m_ok    = s_r.alm_min[7] || (s_r.alm_min[6:0] == cif.nxt.min[6:0]);  // see R10
    assign h_ok    = s_r.alm_hr[7] || (s_r.alm_hr[6:0] == cif.nxt.hour[6:0]);   // see R10
    assign d_ok    = s_r.alm_day[7] || (s_r.alm_day[2:0] == cif.nxt.day[2:0]);  // see R10
    assign tod_evt = tick && cif.min_roll && m_ok && h_ok && d_ok;             // see R11 see R7

    // Watchdog fires on the tick that brings the count to zero.
    assign wd_iv  = {s_r.wd_hi, s_r.wd_lo};
    assign wd_evt = tick && (wd_iv != 16'h0000) && (s_r.wd_cnt <= 16'h0001); // see R26 see R17

    // Pin routing and masking.
    assign tod_act = s_r.tod_flag && !tdm;        // see R21
    assign wd_act  = s_r.wd_flag && !wdog_irq_mask;         // see R21
    assign a_act   = route ? tod_act : wd_act;    // see R18
    assign b_act   = route ? wd_act : tod_act;    // see R18

    // ==========================================
    // Next-state logic.
    always_comb begin
        s_nxt        = s_r;
        s_nxt.xtal_q = xtal_clk;
        s_nxt.wr_q   = wr_now;
        s_nxt.rd_q   = rd_now;

        // Prescaler and square-wave divider only move while the oscillator runs.
        if (xedge && !s_r.osc_stop_n) begin
            s_nxt.acc    = sum[14:0];
            s_nxt.sq_div = s_r.sq_div + 4'h1;
            if (s_r.sq_div == `RAWC_SQW_HALF) begin
                s_nxt.sqw = ~s_r.sqw; // see R3
            end
        end

        // Internal copy always advances; the visible copy follows only with transfers on.
        if (tick) begin
            s_nxt.itm = cif.nxt; // see R6
            if (te) begin
                s_nxt.etm = cif.nxt; // see R5 see R7
            end
        end

        // Host writes land in both copies so a new time takes effect at once.
        if (wr_st) begin
            case (addr)
                `RAWC_A_HUND: begin
                    s_nxt.etm.hund = dq_i;
                    s_nxt.itm.hund = dq_i;
                end
                `RAWC_A_SEC: begin
                    s_nxt.etm.sec = dq_i & `RAWC_M_SEC; // see R1
                    s_nxt.itm.sec = dq_i & `RAWC_M_SEC;
                end
                `RAWC_A_MIN: begin
                    s_nxt.etm.min = dq_i & `RAWC_M_SEC; // see R1
                    s_nxt.itm.min = dq_i & `RAWC_M_SEC;
                end
                `RAWC_A_HOUR: begin
                    s_nxt.etm.hour = dq_i & `RAWC_M_HOUR; // see R1 see R4
                    s_nxt.itm.hour = dq_i & `RAWC_M_HOUR;
                end
                `RAWC_A_DAY: begin
                    s_nxt.etm.day = dq_i & `RAWC_M_DAY; // see R1
                    s_nxt.itm.day = dq_i & `RAWC_M_DAY;
                end
                `RAWC_A_DATE: begin
                    s_nxt.etm.date = dq_i & `RAWC_M_DATE; // see R1
                    s_nxt.itm.date = dq_i & `RAWC_M_DATE;
                end
                `RAWC_A_MON: begin
                    s_nxt.etm.month = dq_i & `RAWC_M_MON; // see R1
                    s_nxt.itm.month = dq_i & `RAWC_M_MON;
                    s_nxt.osc_stop_n = dq_i[`RAWC_B_OSC]; // see R2
                    s_nxt.sqw_off    = dq_i[`RAWC_B_SQW]; // see R3
                end
                `RAWC_A_YEAR: begin
                    s_nxt.etm.year = dq_i;
                    s_nxt.itm.year = dq_i;
                end
                `RAWC_A_AMIN:  s_nxt.alm_min = dq_i;
                `RAWC_A_AHOUR: s_nxt.alm_hr  = dq_i;
                `RAWC_A_ADAY:  s_nxt.alm_day = dq_i & `RAWC_M_ADAY; // see R9
                `RAWC_A_CMD:   s_nxt.cmd     = dq_i[7:2];           // see R22 see R24
                `RAWC_A_WDLO:  s_nxt.wd_lo   = dq_i;                // see R13
                `RAWC_A_WDHI:  s_nxt.wd_hi   = dq_i;                // see R13
                default: begin
                end
            endcase
        end

        // Watchdog countdown; an access restarts from the interval just stored.
        if (wd_clr) begin
            s_nxt.wd_cnt = {s_nxt.wd_hi, s_nxt.wd_lo}; // see R14
        end else if (tick && wd_iv != 16'h0000) begin
            s_nxt.wd_cnt = wd_evt ? wd_iv : bcd_dec(s_r.wd_cnt); // see R15 see R26
        end

        // Time alarm flag: clear by access, end of pulse, then a new event wins.
        if (tod_clr) begin
            s_nxt.tod_flag = 1'b0; // see R12
            s_nxt.tod_pls  = 16'h0000;
        end else begin
            if (s_r.tod_pls != 16'h0000) begin
                s_nxt.tod_pls = s_r.tod_pls - 16'h0001;
            end
            if (pulse && s_r.tod_pls <= 16'h0001) begin
                s_nxt.tod_flag = 1'b0; // see R20 see R22
            end
        end
        if (tod_evt) begin
            s_nxt.tod_flag = 1'b1; // see R22
            s_nxt.tod_pls  = PLS;
        end

        // Watchdog flag follows the same pattern.
        if (wd_clr) begin
            s_nxt.wd_flag = 1'b0; // see R14
            s_nxt.wd_pls  = 16'h0000;
        end else begin
            if (s_r.wd_pls != 16'h0000) begin
                s_nxt.wd_pls = s_r.wd_pls - 16'h0001;
            end
            if (pulse && s_r.wd_pls <= 16'h0001) begin
                s_nxt.wd_flag = 1'b0; // see R20 see R22
            end
        end
        if (wd_evt) begin
            s_nxt.wd_flag = 1'b1; // see R15 see R22
            s_nxt.wd_pls  = PLS;
        end

        // Read data; the watchdog bytes give the interval, never the count.
        case (addr)
            `RAWC_A_HUND:  s_nxt.rdata = s_r.etm.hund;
            `RAWC_A_SEC:   s_nxt.rdata = s_r.etm.sec;
            `RAWC_A_MIN:   s_nxt.rdata = s_r.etm.min;
            `RAWC_A_AMIN:  s_nxt.rdata = s_r.alm_min;
            `RAWC_A_HOUR:  s_nxt.rdata = s_r.etm.hour;
            `RAWC_A_AHOUR: s_nxt.rdata = s_r.alm_hr;
            `RAWC_A_DAY:   s_nxt.rdata = s_r.etm.day;
            `RAWC_A_ADAY:  s_nxt.rdata = s_r.alm_day;
            `RAWC_A_DATE:  s_nxt.rdata = s_r.etm.date;
            `RAWC_A_MON:   s_nxt.rdata = {s_r.osc_stop_n, s_r.sqw_off, s_r.etm.month[5:0]};
            `RAWC_A_YEAR:  s_nxt.rdata = s_r.etm.year;
            `RAWC_A_CMD:   s_nxt.rdata = {s_r.cmd, s_r.wd_flag, s_r.tod_flag};
            `RAWC_A_WDLO:  s_nxt.rdata = s_r.wd_lo; // see R16
            `RAWC_A_WDHI:  s_nxt.rdata = s_r.wd_hi; // see R16
            default:       s_nxt.rdata = 8'h00;
        endcase
        s_nxt.dq_oe_b = !rd_now;

        // Pin drivers. B sources only with supply present, since the source leg has no backup.
        s_nxt.irq_a_oe_b = !a_act;
        s_nxt.irq_b_o    = bpol;                              // see R19
        s_nxt.irq_b_oe_b = !(b_act && (!bpol || vcc_ok));     // see R19
        s_nxt.sqw_oe_b   = s_r.sqw_off;                       // see R3
    end

    // ==========================================
    // State register.
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= ST_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Pin A only ever pulls low.
    assign irq_out_a  = 1'b0;
    assign irq_a_oe_b = s_r.irq_a_oe_b;
    assign irq_out_b  = s_r.irq_b_o;
    assign irq_b_oe_b = s_r.irq_b_oe_b;
    assign dq_o       = s_r.rdata;
    assign dq_oe_b    = s_r.dq_oe_b;
    assign sqw_o      = s_r.sqw;
    assign sqw_oe_b   = s_r.sqw_oe_b;

    // ==========================================
    // Checks.
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence seq_tod_pulse_set;
        tod_evt && pulse && !tod_clr;
    endsequence

    sequence seq_tod_pulse_hold;
        s_r.tod_flag [*3];
    endsequence

    AST_SEC_TOP_ZERO: assert property (rd_st && addr == `RAWC_A_SEC |=> dq_o[7] == 1'b0) // see R1
        else $error("seconds bit 7 read back nonzero");
    AST_OSC_HALT: assert property (s_r.osc_stop_n && !wr_st |=> $stable(s_r.itm) && $stable(s_r.acc)) // see R2
        else $error("time or prescaler moved while oscillator stopped");
    AST_SQW_HIZ: assert property (s_r.sqw_off |=> sqw_oe_b) // see R3
        else $error("square wave driven while disabled");
    AST_FROZEN: assert property (!te && !wr_st |=> s_r.etm == $past(s_r.etm)) // see R5
        else $error("visible time moved while frozen");
    AST_ADAY_ZERO: assert property (rd_st && addr == `RAWC_A_ADAY |=> dq_o[6:3] == 4'h0) // see R9
        else $error("day alarm bits 6..3 nonzero");
    AST_TOD_CLR: assert property (tod_clr && !tod_evt |=> !s_r.tod_flag ##1 (route ? irq_a_oe_b : irq_b_oe_b)) // see R12
        else $error("time alarm not cleared by access");
    AST_WD_RELOAD: assert property (wd_clr && !wd_evt |=> !s_r.wd_flag && s_r.wd_cnt == wd_iv) // see R14
        else $error("watchdog not reloaded by access");
    AST_WD_OFF: assert property (wd_iv == 16'h0000 && !wd_clr |=> !$rose(s_r.wd_flag) && $stable(s_r.wd_cnt)) // see R17
        else $error("watchdog fired with zero interval");
    AST_ROUTE_A: assert property (route && tod_act |=> !irq_a_oe_b) // see R18
        else $error("pin A not driven by time alarm");
    AST_PULSE_HOLD: assert property (seq_tod_pulse_set |=> seq_tod_pulse_hold) // see R20
        else $error("time alarm pulse too short");
    AST_PULSE_END: assert property (pulse && s_r.tod_pls == 16'h0000 && !tod_evt |=> !s_r.tod_flag) // see R22
        else $error("time flag outlived its pulse");

endmodule : rawc_core
`default_nettype wire

// >>> bench/rawc_host.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host processor model on the memory-style bus.
module rawc_host (
    // Bus toward the core.
    input  wire logic       mclk,
    output logic            ce_b,
    output logic            oe_b,
    output logic            we_b,
    output logic      [3:0] addr,
    output logic      [7:0] dq_i,
    input  wire logic [7:0] dq_o
);
    // Bus idles with all strobes released.
    initial begin
        {ce_b, oe_b, we_b, addr, dq_i} = {3'b111, 4'h0, 8'h00};
    end

    // One write; released data is inverted so a stale byte is never mistaken for a hold.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk);
        {ce_b, we_b, addr, dq_i} = {2'b00, a, d};
        @(negedge mclk);
        {ce_b, we_b, dq_i} = {2'b11, ~d};
        @(negedge mclk);
    endtask : wr

    // One read; data is taken two cycles after the strobes fall, then one idle cycle.
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge mclk);
        {ce_b, oe_b, addr} = {2'b00, a};
        repeat (2) @(negedge mclk);
        d = dq_o;
        {ce_b, oe_b} = 2'b11;
        @(negedge mclk);
    endtask : rd
endmodule : rawc_host
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "rawc_cfg.svh"
// ==========================================
// Self-checking bench for the timekeeping core.
module testbench;
    logic       mclk, rst_b, xtal_clk, ce_b, oe_b, we_b, dq_oe_b, irq_out_a, irq_a_oe_b;
    logic       irq_out_b, irq_b_oe_b, sqw_o, sqw_oe_b, vcc_ok;
    logic [3:0] addr;
    logic [7:0] dq_i, dq_o, rv;
    int         error_cnt = 0;
    int         comparisons = 0;
    int         low_cnt = 0;
    int         low_base;

    // Short pulse length keeps the run brief; supply drops once to test pin B sourcing.
    rawc_core #(.PULSE_CYC(8)) u_rawc_core (.mclk, .rst_b, .xtal_clk, .vcc_ok, .ce_b, .oe_b, .we_b,
        .addr, .dq_i, .dq_o, .dq_oe_b, .irq_out_a, .irq_a_oe_b, .irq_out_b, .irq_b_oe_b, .sqw_o, .sqw_oe_b);
    rawc_host u_rawc_host (.mclk, .ce_b, .oe_b, .we_b, .addr, .dq_i, .dq_o);

    // Verdict and end of run.
    task automatic end_sim;
        if (error_cnt == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_sim

    // Compare one byte and count it.
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Read a register and compare it.
    task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
        u_rawc_host.rd(a, rv);
        chk(n, e, rv);
    endtask : rc

    // Clock; the crystal runs far faster than real so a hundredth takes some 650 cycles.
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    initial begin
        xtal_clk = 1'b0;
        forever @(negedge mclk) xtal_clk <= ~xtal_clk;
    end

    // Cycles with pin A active, sampled away from the launching edge.
    always @(negedge mclk) begin
        if (!irq_a_oe_b) begin
            low_cnt <= low_cnt + 1;
        end
    end

    // Watchdog: the tests need under 8000 cycles.
    initial begin
        #3_000_000;
        error_cnt++;
        end_sim();
    end

    // Main sequence.
    initial begin
        rst_b = 1'b0;
        vcc_ok = 1'b1;
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        rc("cmd", `RAWC_A_CMD, 8'hCC);
        rc("mon", `RAWC_A_MON, 8'hC1);
        u_rawc_host.wr(`RAWC_A_ADAY, 8'hFF);
        rc("aday", `RAWC_A_ADAY, 8'h87);
        u_rawc_host.wr(`RAWC_A_HOUR, 8'hFF);
        rc("hour", `RAWC_A_HOUR, 8'h7F);
        // All masks set: alarm at the seconds roll; the watchdog interval stays zero.
        u_rawc_host.wr(`RAWC_A_AMIN, 8'h80);
        u_rawc_host.wr(`RAWC_A_AHOUR, 8'h80);
        u_rawc_host.wr(`RAWC_A_CMD, 8'hC8);
        u_rawc_host.wr(`RAWC_A_SEC, 8'h59);
        u_rawc_host.wr(`RAWC_A_HUND, 8'h99);
        u_rawc_host.wr(`RAWC_A_MON, 8'h01);
        chk("pins", 8'h01, {5'h00, irq_out_a, sqw_oe_b, dq_oe_b});
        repeat (1400) @(negedge mclk);
        rc("cmd", `RAWC_A_CMD, 8'hC9);
        chk("irq_a", 8'h00, {7'h00, irq_a_oe_b});
        rc("sec", `RAWC_A_SEC, 8'h00);
        rc("amin", `RAWC_A_AMIN, 8'h80);
        chk("irq_a", 8'h01, {7'h00, irq_a_oe_b});
        // Swapped routing: pin A now carries the watchdog, five hundredths.
        u_rawc_host.wr(`RAWC_A_CMD, 8'h84);
        u_rawc_host.wr(`RAWC_A_WDLO, 8'h05);
        rc("wdlo", `RAWC_A_WDLO, 8'h05);
        repeat (3500) @(negedge mclk);
        rc("cmd", `RAWC_A_CMD, 8'h86);
        chk("irq_a", 8'h00, {7'h00, irq_a_oe_b});
        chk("irq_b", 8'h01, {7'h00, irq_b_oe_b});
        // Pin B carries the watchdog and sources current only while supply is present.
        u_rawc_host.wr(`RAWC_A_CMD, 8'hE4);
        chk("irq_b", 8'h02, {6'h00, irq_out_b, irq_b_oe_b});
        vcc_ok = 1'b0;
        @(negedge mclk);
        chk("irq_b", 8'h03, {6'h00, irq_out_b, irq_b_oe_b});
        vcc_ok = 1'b1;
        u_rawc_host.wr(`RAWC_A_CMD, 8'h84);
        rc("wdhi", `RAWC_A_WDHI, 8'h00);
        chk("irq_a", 8'h01, {7'h00, irq_a_oe_b});
        rc("cmd", `RAWC_A_CMD, 8'h84);
        // Pulse mode with the watchdog off; time is set while frozen and stopped.
        u_rawc_host.wr(`RAWC_A_WDLO, 8'h00);
        u_rawc_host.wr(`RAWC_A_CMD, 8'h58);
        u_rawc_host.wr(`RAWC_A_MON, 8'h81);
        u_rawc_host.wr(`RAWC_A_SEC, 8'h59);
        u_rawc_host.wr(`RAWC_A_HUND, 8'h99);
        low_base = low_cnt;
        u_rawc_host.wr(`RAWC_A_MON, 8'h01);
        u_rawc_host.wr(`RAWC_A_CMD, 8'hD8);
        repeat (1400) @(negedge mclk);
        chk("pulse_len", 8'h08, 8'(low_cnt - low_base));
        rc("cmd", `RAWC_A_CMD, 8'hD8);
        end_sim();
    end
endmodule : testbench
`default_nettype wire
